// File: src/mfs_regs.svh
`ifndef MFS_REGS_SVH
`define MFS_REGS_SVH

// Counter indices; the byte offset of a counter is four times its index.
`define MFS_IDX_RX_FILT      4'h0
`define MFS_IDX_RX_QOS       4'h1
`define MFS_IDX_RX_OCT       4'h2
`define MFS_IDX_TX_GOOD      4'h3
`define MFS_IDX_TX_BCAST     4'h4
`define MFS_IDX_TX_MCAST     4'h5
`define MFS_IDX_TX_PAUSE     4'h6
`define MFS_IDX_TX_DEFER     4'h7
`define MFS_IDX_TX_COLL      4'h8
`define MFS_IDX_TX_ONE       4'h9
`define MFS_IDX_TX_SEVERAL   4'ha
`define MFS_IDX_TX_ABANDON   4'hb
`define MFS_IDX_TX_LATE      4'hc
`define MFS_IDX_TX_STARVED   4'hd
`define MFS_IDX_TX_CARRIER   4'he
`define MFS_IDX_TX_OCT       4'hf
`define MFS_NUM_COUNTERS     16

// Byte offsets of the control and status words.
`define MFS_OFS_CTRL         8'h40
`define MFS_OFS_MAXLEN       8'h44
`define MFS_OFS_STATUS       8'h48

// Fields of port_control_register.
`define MFS_CTRL_GIG_BIT     0
`define MFS_CTRL_QOS_BIT     1
`define MFS_CTRL_IRQEN_BIT   2
`define MFS_CTRL_RESET       3'h0

// Fields of the status word.
`define MFS_STAT_PEND_BIT    0
`define MFS_STAT_INIT_BIT    1

// Frame and timing figures.
`define MFS_MAXLEN_RESET     16'h05ee
`define MFS_MIN_FRAME        16'h0040
`define MFS_FRAME64          16'h0040
`define MFS_INIT_CLOCKS      6'h26
`define MFS_COLL_ABANDON     5'h10
`define MFS_COLL_MULTI_MAX   5'h0f
`define MFS_BCAST_ADDR       48'hffffffffffff
`define MFS_FULL_STROBE      4'hf

`endif

// File: src/mfs_pkg.sv
package mfs_pkg;

  typedef enum logic {
    MFS_INIT,
    MFS_RUN
  } mfs_phase_e;

  typedef struct packed {
    logic [31:0] cnt;
  } mfs_cnt_s;

  typedef struct packed {
    mfs_phase_e  phase;
    logic [5:0]  init_cnt;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        gig_en;
    logic        qos_en;
    logic        irq_en;
    logic [15:0] max_len;
    logic [4:0]  coll_tally;
    logic        late_seen;
    logic        abandon;
    logic        frame64;
    logic        irq;
  } mfs_top_s;

endpackage

// File: src/mfs_counter.sv
`timescale 1ns/1ns
module mfs_counter
  import mfs_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset.
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // Control.
  input  wire logic         i_clear,
  input  wire logic         i_wr_en,
  input  wire logic         i_sub_mode,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic [W-1:0] i_inc,
  // Value.
  output logic      [W-1:0] o_count
);

  mfs_cnt_s st_ff;
  mfs_cnt_s nxt_st;
  logic [W-1:0] base;

  always_comb begin
    nxt_st = st_ff;
    base   = st_ff.cnt[W-1:0];
    if (i_wr_en) begin
      if (i_sub_mode) begin
        base = (i_wdata > st_ff.cnt[W-1:0]) ? '0 : st_ff.cnt[W-1:0] - i_wdata;
      end else begin
        base = i_wdata;
      end
    end
    // The add follows the write so that an event in the write cycle is kept.
    nxt_st.cnt[W-1:0] = base + i_inc;
    if (i_clear) begin
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_count = st_ff.cnt[W-1:0];

endmodule // mfs_counter

// File: src/mfs_stats.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "mfs_regs.svh"
// How it works
// - Count unmatched clean data frames as filtered.
// - Count QoS drops when threshold reaches free buffers.
// - Add good received frame bytes to total.
// - Count transmitted frames without fatal errors.
// - Count good frames sent to broadcast.
// - Count good non-broadcast multicast transmitted frames.
// - Count only hardware-generated pause frames.
// - Hardware pause also counts multicast and 64-byte.
// - Count clean deferred frames without collisions.
// - Add every collision of clean non-pause frames.
// - Half-duplex flow-control receive start adds collision.
// - Count success after exactly one collision.
// - Count success after two to fifteen collisions.
// - Abandon after sixteen collisions, count it.
// - Late collision abandons frame, counted unless hardware pause.
// - Late collision excludes single, multiple, excessive counters.
// - Count frames that suffered transmit underrun.
// - Count frames with lost carrier.
// - Add good transmitted frame bytes to total.
// - Gigabit mode writes subtract with zero floor.
// - Interrupt while any counter has top bit.
// - 32-bit wrapping counters, cleared 38 clocks after reset.
module mfs_stats
  import mfs_pkg::*;
#(
  parameter logic [15:0] MAX_LEN_RESET = `MFS_MAXLEN_RESET
) (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive frame status.
  input  wire logic        i_rx_done,
  input  wire logic        i_rx_is_control,
  input  wire logic        i_rx_addr_match,
  input  wire logic        i_rx_promisc_accept,
  input  wire logic        i_rx_crc_err,
  input  wire logic        i_rx_align_err,
  input  wire logic        i_rx_code_err,
  input  wire logic [15:0] i_rx_byte_count,
  input  wire logic [15:0] i_rx_channel_flow_threshold,
  input  wire logic [15:0] i_rx_channel_free_buffers,
  input  wire logic        i_rx_start,
  input  wire logic        i_half_duplex,
  input  wire logic        i_rx_flow_active,
  // Transmit attempt and frame status.
  input  wire logic        i_tx_coll,
  input  wire logic        i_tx_coll_late,
  input  wire logic        i_tx_done,
  input  wire logic        i_tx_pause_hw,
  input  wire logic        i_tx_deferred,
  input  wire logic        i_tx_carrier_lost,
  input  wire logic        i_tx_underrun,
  input  wire logic [47:0] i_tx_dest_addr,
  input  wire logic [15:0] i_tx_byte_count,
  // Outputs to the MAC and the system.
  output logic             o_tx_abandon,
  output logic             o_tx_frame64_evt,
  output logic             o_statistics_interrupt_pending
);

  localparam int N = `MFS_NUM_COUNTERS;

  mfs_top_s    st_ff;
  mfs_top_s    nxt_st;
  logic [31:0] cnt_val [N];
  logic [31:0] cnt_inc [N];
  logic [N-1:0] cnt_wr;
  logic        clear_all;
  logic        apb_access;
  logic        apb_commit;
  logic        is_counter;
  logic [3:0]  reg_idx;
  logic        full_word;
  logic        rx_err;
  logic        rx_accept;
  logic        rx_len_ok;
  logic        tx_clean;
  logic        tx_ok;
  logic        tx_bcast;
  logic        tx_mcast;
  logic [4:0]  tally_now;
  logic [N-1:0] top_bits;

  assign apb_access = psel && penable;
  assign apb_commit = apb_access && st_ff.pready;
  assign is_counter = (paddr[7:6] == 2'b00);
  assign reg_idx    = paddr[5:2];
  assign full_word  = (pstrb == `MFS_FULL_STROBE);
  assign clear_all  = (st_ff.phase == MFS_INIT);

  // Receive classification.
  assign rx_err    = i_rx_crc_err || i_rx_align_err || i_rx_code_err;
  assign rx_accept = i_rx_addr_match || i_rx_promisc_accept;
  assign rx_len_ok = (i_rx_byte_count >= `MFS_MIN_FRAME) &&
                     (i_rx_byte_count <= st_ff.max_len);

  // Transmit classification.
  assign tx_clean  = !i_tx_carrier_lost && !i_tx_underrun;
  assign tx_ok     = tx_clean && !st_ff.late_seen &&
                     (st_ff.coll_tally < `MFS_COLL_ABANDON);
  assign tx_bcast  = (i_tx_dest_addr == `MFS_BCAST_ADDR);
  assign tx_mcast  = i_tx_dest_addr[40] && !tx_bcast;
  assign tally_now = st_ff.coll_tally;

  // Per-counter increments; every counter sees the same frame event in one cycle.
  always_comb begin
    for (int k = 0; k < N; k++) begin
      cnt_inc[k] = 32'h0;
    end
    if (i_rx_done && !clear_all) begin
      if (!i_rx_is_control && !rx_err && !rx_accept) begin
        cnt_inc[`MFS_IDX_RX_FILT] = 32'h1;
      end
      if (st_ff.qos_en && rx_accept && rx_len_ok && !rx_err &&
          (i_rx_channel_flow_threshold >= i_rx_channel_free_buffers)) begin
        cnt_inc[`MFS_IDX_RX_QOS] = 32'h1;
      end
      if (rx_accept && rx_len_ok && !rx_err) begin
        cnt_inc[`MFS_IDX_RX_OCT] = {16'h0, i_rx_byte_count};
      end
    end
    if (i_tx_done && !clear_all) begin
      if (i_tx_pause_hw) begin
        cnt_inc[`MFS_IDX_TX_PAUSE] = 32'h1;
        cnt_inc[`MFS_IDX_TX_MCAST] = 32'h1;
        cnt_inc[`MFS_IDX_TX_GOOD]  = 32'h1;
        cnt_inc[`MFS_IDX_TX_OCT]   = {16'h0, `MFS_FRAME64};
      end else begin
        if (tx_ok) begin
          cnt_inc[`MFS_IDX_TX_GOOD] = 32'h1;
          cnt_inc[`MFS_IDX_TX_OCT]  = {16'h0, i_tx_byte_count};
          if (tx_bcast) begin
            cnt_inc[`MFS_IDX_TX_BCAST] = 32'h1;
          end
          if (tx_mcast) begin
            cnt_inc[`MFS_IDX_TX_MCAST] = 32'h1;
          end
        end
        if (tx_clean && i_tx_deferred && (tally_now == 5'h0)) begin
          cnt_inc[`MFS_IDX_TX_DEFER] = 32'h1;
        end
        if (tx_clean) begin
          cnt_inc[`MFS_IDX_TX_COLL] = {27'h0, tally_now};
        end
        if (tx_clean && !st_ff.late_seen) begin
          if (tally_now == 5'h1) begin
            cnt_inc[`MFS_IDX_TX_ONE] = 32'h1;
          end
          if ((tally_now >= 5'h2) && (tally_now <= `MFS_COLL_MULTI_MAX)) begin
            cnt_inc[`MFS_IDX_TX_SEVERAL] = 32'h1;
          end
          if (tally_now == `MFS_COLL_ABANDON) begin
            cnt_inc[`MFS_IDX_TX_ABANDON] = 32'h1;
          end
        end
        if (st_ff.late_seen) begin
          cnt_inc[`MFS_IDX_TX_LATE] = 32'h1;
        end
        if (i_tx_underrun) begin
          cnt_inc[`MFS_IDX_TX_STARVED] = 32'h1;
        end
        if (i_tx_carrier_lost) begin
          cnt_inc[`MFS_IDX_TX_CARRIER] = 32'h1;
        end
      end
    end
    // A receive start under half-duplex flow control stacks onto any frame tally.
    if (i_rx_start && i_half_duplex && i_rx_flow_active && !clear_all) begin
      cnt_inc[`MFS_IDX_TX_COLL] = cnt_inc[`MFS_IDX_TX_COLL] + 32'h1;
    end
  end

  // Register writes take effect only at the completing edge of the access.
  always_comb begin
    cnt_wr = '0;
    if (apb_commit && pwrite && is_counter && full_word && !clear_all) begin
      cnt_wr[reg_idx] = 1'b1;
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_cnt
    mfs_counter #(
      .W (32)
    ) u_cnt (
      .i_clock    (i_clock),
      .i_resetn   (i_resetn),
      .i_clear    (clear_all),
      .i_wr_en    (cnt_wr[g]),
      .i_sub_mode (st_ff.gig_en),
      .i_wdata    (pwdata),
      .i_inc      (cnt_inc[g]),
      .o_count    (cnt_val[g])
    );
    assign top_bits[g] = cnt_val[g][31];
  end

  always_comb begin
    nxt_st = st_ff;
    // Counters stay cleared for a fixed number of clocks after reset release.
    case (st_ff.phase)
      MFS_INIT: begin
        if (st_ff.init_cnt == `MFS_INIT_CLOCKS - 6'h1) begin
          nxt_st.phase = MFS_RUN;
        end else begin
          nxt_st.init_cnt = st_ff.init_cnt + 6'h1;
        end
      end
      MFS_RUN: begin
        nxt_st.init_cnt = st_ff.init_cnt;
      end
      default: begin
        nxt_st.phase = MFS_INIT;
      end
    endcase

    // APB: one wait state, then pready with the answer.
    nxt_st.pready  = apb_access && !st_ff.pready;
    if (apb_access && !st_ff.pready) begin
      nxt_st.prdata  = 32'h0;
      nxt_st.pslverr = 1'b0;
      if (is_counter) begin
        nxt_st.prdata  = cnt_val[reg_idx];
        nxt_st.pslverr = pwrite && !full_word;
      end else if (paddr == `MFS_OFS_CTRL) begin
        nxt_st.prdata = {29'h0, st_ff.irq_en, st_ff.qos_en, st_ff.gig_en};
      end else if (paddr == `MFS_OFS_MAXLEN) begin
        nxt_st.prdata = {16'h0, st_ff.max_len};
      end else if (paddr == `MFS_OFS_STATUS) begin
        nxt_st.prdata = {30'h0, clear_all, st_ff.irq};
        nxt_st.pslverr = pwrite;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
    if (apb_commit && pwrite && (paddr == `MFS_OFS_CTRL)) begin
      nxt_st.gig_en = pwdata[`MFS_CTRL_GIG_BIT];
      nxt_st.qos_en = pwdata[`MFS_CTRL_QOS_BIT];
      nxt_st.irq_en = pwdata[`MFS_CTRL_IRQEN_BIT];
    end
    if (apb_commit && pwrite && (paddr == `MFS_OFS_MAXLEN)) begin
      nxt_st.max_len = pwdata[15:0];
    end

    // Per-frame collision tally; the engine marks late collisions past 512 bit-times.
    nxt_st.abandon = 1'b0;
    if (i_tx_coll && !i_tx_done) begin
      nxt_st.coll_tally = st_ff.coll_tally + 5'h1;
      if (i_tx_coll_late) begin
        nxt_st.late_seen = 1'b1;
        nxt_st.abandon   = 1'b1;
      end else if (st_ff.coll_tally == `MFS_COLL_ABANDON - 5'h1) begin
        nxt_st.abandon = 1'b1;
      end
    end
    if (i_tx_done) begin
      nxt_st.coll_tally = 5'h0;
      nxt_st.late_seen  = 1'b0;
    end

    // Pause frames are always 64 bytes; good 64-byte frames feed the histogram too.
    nxt_st.frame64 = i_tx_done && !clear_all &&
                     (i_tx_pause_hw || (tx_ok && (i_tx_byte_count == `MFS_FRAME64)));

    // Level interrupt: falls as soon as software brings all counters below the top bit.
    nxt_st.irq = st_ff.irq_en && (|top_bits);
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff          <= '0;
      st_ff.phase    <= MFS_INIT;
      st_ff.max_len  <= MAX_LEN_RESET;
      st_ff.gig_en   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata                         = st_ff.prdata;
  assign pready                         = st_ff.pready;
  assign pslverr                        = st_ff.pslverr;
  assign o_tx_abandon                   = st_ff.abandon;
  assign o_tx_frame64_evt               = st_ff.frame64;
  assign o_statistics_interrupt_pending = st_ff.irq;

endmodule // mfs_stats

// File: verif/mfs_stats_props.sv
`timescale 1ns/1ns
module mfs_stats_props (
  // Clock and reset.
  input wire logic        i_clock,
  input wire logic        i_resetn,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Frame events.
  input wire logic        i_tx_coll,
  input wire logic        i_tx_coll_late,
  input wire logic        i_tx_done,
  input wire logic        i_tx_pause_hw,
  input wire logic        o_tx_abandon,
  input wire logic        o_tx_frame64_evt,
  input wire logic        o_statistics_interrupt_pending
);
  logic [5:0] cyc_ff;
  logic [4:0] coll_ff;
  logic       up;
  // Frame checks wait until init is surely over, since the counters ignore events before.
  assign up = cyc_ff > 6'h27;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc_ff  <= 6'h0;
      coll_ff <= 5'h0;
    end else begin
      cyc_ff  <= up ? cyc_ff : cyc_ff + 6'h1;
      coll_ff <= i_tx_done ? 5'h0 : coll_ff + 5'(up && i_tx_coll && !i_tx_coll_late);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_unmapped_read: assert property (psel && penable && pready && paddr > 8'h48
    |-> pslverr && prdata == 32'h0) else $error("unmapped access answered");
  a_partial_write: assert property (psel && penable && pready && pwrite && paddr < 8'h40
    && pstrb != 4'hf |-> pslverr) else $error("partial write accepted");
  a_late_abandon: assert property (up && i_tx_coll && i_tx_coll_late |=> o_tx_abandon)
    else $error("late collision kept");
  a_excess_abandon: assert property (up && i_tx_coll && !i_tx_coll_late && coll_ff == 5'hf
    |=> o_tx_abandon) else $error("16th collision kept");
  a_early_keep: assert property (up && i_tx_coll && !i_tx_coll_late && coll_ff < 5'hf
    |=> !o_tx_abandon) else $error("early abandon");
  a_pause_frame64: assert property (up && i_tx_done && i_tx_pause_hw |=> o_tx_frame64_evt)
    else $error("pause frame not 64 bytes");
  a_init_quiet: assert property (cyc_ff < 6'h26 |-> !o_statistics_interrupt_pending)
    else $error("interrupt during init");
endmodule // mfs_stats_props
bind mfs_stats mfs_stats_props i_mfs_stats_props (.*);

// File: verif/mfs_mac_model.sv
`timescale 1ns/1ns
module mfs_mac_model (
  // Clock.
  input  wire logic   i_clock,
  // Receive engine.
  output logic        o_rx_done,
  output logic [5:0]  o_rx_flags,
  output logic [15:0] o_rx_len,
  output logic [15:0] o_rx_thr,
  output logic [15:0] o_rx_free,
  output logic        o_rx_start,
  output logic [1:0]  o_rx_mode,
  // Transmit engine.
  output logic        o_tx_coll,
  output logic        o_tx_late,
  output logic        o_tx_done,
  output logic [3:0]  o_tx_flags,
  output logic [47:0] o_tx_dest,
  output logic [15:0] o_tx_len
);
  initial begin
    {o_rx_done, o_rx_flags, o_rx_len, o_rx_thr, o_rx_free, o_rx_start, o_rx_mode} = '0;
    {o_tx_coll, o_tx_late, o_tx_done, o_tx_flags, o_tx_dest, o_tx_len} = '0;
  end
  // Status only means something with its strobe; afterwards it is inverted so that
  // a late sample sees the wrong value rather than a lucky stale one.
  task automatic rx(input logic [5:0] f, input logic [15:0] n, t, b);
    @(posedge i_clock);
    {o_rx_done, o_rx_flags, o_rx_len, o_rx_thr, o_rx_free} <= {1'b1, f, n, t, b};
    @(posedge i_clock);
    {o_rx_done, o_rx_flags, o_rx_len, o_rx_thr, o_rx_free} <= {1'b0, ~f, ~n, ~t, ~b};
  endtask
  task automatic rs(input logic [1:0] m);
    @(posedge i_clock);
    {o_rx_start, o_rx_mode} <= {1'b1, m};
    @(posedge i_clock);
    {o_rx_start, o_rx_mode} <= {1'b0, ~m};
  endtask
  task automatic tx(input int n, input logic late, input logic [3:0] f,
                    input logic [47:0] d, input logic [15:0] len);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clock);
      {o_tx_coll, o_tx_late} <= {1'b1, late && i == n - 1};
      @(posedge i_clock);
      {o_tx_coll, o_tx_late} <= {1'b0, !(late && i == n - 1)};
    end
    @(posedge i_clock);
    {o_tx_done, o_tx_flags, o_tx_dest, o_tx_len} <= {1'b1, f, d, len};
    @(posedge i_clock);
    {o_tx_done, o_tx_flags, o_tx_dest, o_tx_len} <= {1'b0, ~f, ~d, ~len};
  endtask
endmodule // mfs_mac_model

// File: verif/mfs_stats_tb.sv
`timescale 1ns/1ns
`include "mfs_regs.svh"
module mfs_stats_tb;
  logic        i_clock = 1'b0, i_resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, o_tx_abandon, o_tx_frame64_evt, o_statistics_interrupt_pending;
  wire         i_rx_done, i_rx_is_control, i_rx_addr_match, i_rx_promisc_accept, i_rx_crc_err;
  wire         i_rx_align_err, i_rx_code_err, i_rx_start, i_half_duplex, i_rx_flow_active;
  wire         i_tx_coll, i_tx_coll_late, i_tx_done, i_tx_pause_hw, i_tx_deferred;
  wire         i_tx_carrier_lost, i_tx_underrun;
  wire  [15:0] i_rx_byte_count, i_rx_channel_flow_threshold, i_rx_channel_free_buffers;
  wire  [15:0] i_tx_byte_count;
  wire  [47:0] i_tx_dest_addr;
  logic [31:0] want [16];
  logic [31:0] rd;
  logic        er, gig, qos;
  logic [15:0] maxl;
  int          n_fail = 0, tests_run = 0, cyc = 0;

  always #50 i_clock = ~i_clock;

  mfs_mac_model i_mfs_mac_model (
    .i_clock    (i_clock),
    .o_rx_done  (i_rx_done),
    .o_rx_flags ({i_rx_is_control, i_rx_addr_match, i_rx_promisc_accept,
                  i_rx_crc_err, i_rx_align_err, i_rx_code_err}),
    .o_rx_len   (i_rx_byte_count),
    .o_rx_thr   (i_rx_channel_flow_threshold),
    .o_rx_free  (i_rx_channel_free_buffers),
    .o_rx_start (i_rx_start),
    .o_rx_mode  ({i_half_duplex, i_rx_flow_active}),
    .o_tx_coll  (i_tx_coll),
    .o_tx_late  (i_tx_coll_late),
    .o_tx_done  (i_tx_done),
    .o_tx_flags ({i_tx_pause_hw, i_tx_deferred, i_tx_carrier_lost, i_tx_underrun}),
    .o_tx_dest  (i_tx_dest_addr),
    .o_tx_len   (i_tx_byte_count)
  );
  mfs_stats i_mfs_stats (.*);

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, w);
    tests_run++;
    if (got !== w) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, w);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge i_clock);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1)
      @(posedge i_clock);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, `MFS_FULL_STROBE);
    if (a < `MFS_OFS_CTRL)
      want[a[5:2]] = !gig ? d : (d > want[a[5:2]] ? 32'h0 : want[a[5:2]] - d);
  endtask
  task automatic setctl(input logic [2:0] c);
    wr(`MFS_OFS_CTRL, {29'h0, c});
    {qos, gig} = c[1:0];
  endtask
  task automatic rdall();
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
      chk(rd, want[i]);
    end
  endtask
  task automatic stat(input logic [1:0] v);
    apb(1'b0, `MFS_OFS_STATUS, 32'h0, 4'h0);
    chk({30'h0, rd[1:0]}, {30'h0, v});
  endtask
  task automatic irq(input logic v);
    repeat (2) @(posedge i_clock);
    chk({31'h0, o_statistics_interrupt_pending}, {31'h0, v});
    stat({1'b0, v});
  endtask
  task automatic txf(input int n, input logic late, input logic [3:0] f,
                     input logic [47:0] d, input logic [15:0] len);
    logic ok, cl;
    cl = !f[1] && !f[0];
    ok = cl && !late && n < 16;
    i_mfs_mac_model.tx(n, late, f, d, len);
    if (f[3]) begin
      {want[6], want[5], want[3]} = {want[6] + 1, want[5] + 1, want[3] + 1};
      want[15] += 64;
    end else begin
      want[3] += ok;
      want[4] += ok && d == `MFS_BCAST_ADDR;
      want[5] += ok && d[40] && d != `MFS_BCAST_ADDR;
      want[15] += ok ? len : 0;
      want[7] += cl && f[2] && n == 0;
      want[8] += cl ? n : 0;
      want[9] += cl && !late && n == 1;
      want[10] += cl && !late && n > 1 && n < 16;
      want[11] += cl && !late && n == 16;
      want[12] += late;
      {want[13], want[14]} = {want[13] + f[0], want[14] + f[1]};
    end
  endtask
  task automatic rnd();
    int n;
    logic [15:0] len;
    logic [47:0] d;
    logic [5:0] f;
    n = $urandom % 17;
    f = 6'($urandom) & {3'h7, 3'($urandom)};
    d = $urandom % 3 ? {16'($urandom), 32'($urandom)} : `MFS_BCAST_ADDR;
    case ($urandom % 3)
      0: len = 16'd63 + 16'($urandom % 3);
      1: len = maxl - 16'd1 + 16'($urandom % 3);
      default: len = 16'($urandom % 1600);
    endcase
    case ($urandom % 3)
      0: txf(f[3] ? 0 : n, f[4] && n > 0 && !f[3], {f[3], f[2], f[1:0] & 2'($urandom)}, d, len);
      1: rxf(f, len, 16'($urandom % 4), 16'($urandom % 4));
      default: begin
        i_mfs_mac_model.rs(f[1:0]);
        want[8] += f[1:0] == 2'b11;
      end
    endcase
  endtask
  task automatic rxf(input logic [5:0] f, input logic [15:0] len, t, b);
    logic good;
    i_mfs_mac_model.rx(f, len, t, b);
    good = (f[4] || f[3]) && f[2:0] == 3'h0 && len >= 16'd64 && len <= maxl;
    want[0] += !f[5] && !f[4] && !f[3] && f[2:0] == 3'h0;
    want[1] += good && qos && t >= b;
    want[2] += good ? len : 16'h0;
  endtask
  initial begin
    void'($urandom(32'h5685));
    {gig, qos, maxl} = {2'b00, `MFS_MAXLEN_RESET};
    foreach (want[i]) want[i] = 32'h0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    stat(2'b10);
    i_mfs_mac_model.tx(0, 1'b0, 4'h0, 48'h0, 16'd100);
    for (int i = 0; i < 20 && rd[1]; i++)
      apb(1'b0, `MFS_OFS_STATUS, 32'h0, 4'h0);
    stat(2'b00);
    rdall();
    maxl = 16'd1000;
    wr(`MFS_OFS_MAXLEN, {16'h0, maxl});
    apb(1'b0, `MFS_OFS_MAXLEN, 32'h0, 4'h0);
    chk(rd, {16'h0, maxl});
    for (int q = 0; q < 2; q++) begin
      setctl({1'b0, q[0], 1'b0});
      repeat (150) rnd();
      for (int m = 0; m < 4; m++) begin
        i_mfs_mac_model.rs(2'(m));
        want[8] += m == 3;
      end
      txf(16, 1'b0, 4'h0, 48'h0, 16'd100);
      txf(16, 1'b1, 4'h0, 48'h0, 16'd100);
      txf(0, 1'b0, 4'hb, 48'h0, 16'd9);
      rdall();
    end
    apb(1'b1, 8'h0c, 32'h5, 4'h3);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h4c, 32'h0, 4'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, `MFS_OFS_STATUS, 32'h3, `MFS_FULL_STROBE);
    chk({31'h0, er}, 32'h1);
    wr(8'h0c, 32'hffffffff);
    txf(0, 1'b0, 4'h0, 48'h0, 16'd64);
    fork
      wr(8'h0c, 32'h10);
      begin
        repeat (2) @(posedge i_clock);
        i_mfs_mac_model.tx(0, 1'b0, 4'h0, 48'h0, 16'd64);
      end
    join
    want[3] = 32'h11;
    want[15] += 64;
    wr(8'h20, 32'h80000000);
    irq(1'b0);
    setctl(3'h4);
    irq(1'b1);
    setctl(3'h5);
    apb(1'b0, `MFS_OFS_CTRL, 32'h0, 4'h0);
    chk(rd, 32'h5);
    wr(8'h20, 32'h1);
    irq(1'b0);
    wr(8'h24, 32'hffffffff);
    rdall();
    stop_test();
  end
endmodule // mfs_stats_tb
